// ==== tb_top.sv ====
`default_nettype none
module tb_top;
	import wtr_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic core_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic sample_valid_in = 1'b0;
	logic [2:0] sample_chan_in = 3'h0;
	logic [RES_W-1:0] sample_in = 12'h000;
	wtr_reg_wr_t reg_wr;
	logic [7:0] rd_addr, rd_data, ch3_nib, d;
	logic rd_hit, ch3_ev, ch4_ev, h;
	int error_cnt = 0;
	int samples_checked = 0;
	logic [7:0] addr_t [7] = '{8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33};
	logic [7:0] rst_t [7] = '{8'hFF, 8'h00, 8'h00, 8'hF0, 8'hFF, 8'h00, 8'h00};

	// free running clock
	always #2 core_clk_in = ~core_clk_in;

	wtr_host_model u_wtr_host_model (.core_clk_in(core_clk_in), .reg_wr_out(reg_wr),
		.rd_addr_out(rd_addr), .rd_data_in(rd_data), .rd_hit_in(rd_hit),
		.ch3_nib_hyst_out(ch3_nib));
	wtr_window_regs u_wtr_window_regs (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.reg_wr_in(reg_wr), .rd_addr_in(rd_addr), .rd_data_out(rd_data), .rd_hit_out(rd_hit),
		.ch3_nib_hyst_in(ch3_nib), .sample_valid_in(sample_valid_in),
		.sample_chan_in(sample_chan_in), .sample_in(sample_in),
		.ch3_event_out(ch3_ev), .ch4_event_out(ch4_ev));

	// compare and count
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// read one register and compare data and hit
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic ehit);
		u_wtr_host_model.rd_reg(a, d, h);
		chk("rd_data", d, exp);
		chk("rd_hit", {7'h00, h}, {7'h00, ehit});
	endtask

	// k single-cycle samples on one channel
	task automatic run(input logic [2:0] ch, input logic [11:0] v, input int k);
		repeat (k) begin
			@(posedge core_clk_in);
			#1;
			sample_valid_in = 1'b1;
			sample_chan_in = ch;
			sample_in = v;
			@(posedge core_clk_in);
			#1;
			sample_valid_in = 1'b0;
			sample_in = ~v;
		end
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge core_clk_in);
		error_cnt++;
		conclude();
	end

	// main sequence
	initial begin
		repeat (8) @(posedge core_clk_in);
		#1;
		sys_rst_in = 1'b0;
		for (int i = 0; i < 7; i++) rd_chk(addr_t[i], rst_t[i], 1'b1);
		rd_chk(8'h34, 8'h00, 1'b0);
		for (int i = 0; i < 7; i++) u_wtr_host_model.wr_reg(addr_t[i], 8'hA5 ^ 8'(i * 17));
		for (int i = 0; i < 7; i++) rd_chk(addr_t[i], 8'hA5 ^ 8'(i * 17), 1'b1);
		// channel 4: upper 0x805, lower 0x103, margin 8, n = 2
		u_wtr_host_model.wr_reg(8'h30, 8'h51);
		u_wtr_host_model.wr_reg(8'h31, 8'h80);
		u_wtr_host_model.wr_reg(8'h32, 8'h32);
		u_wtr_host_model.wr_reg(8'h33, 8'h10);
		run(3'h4, 12'h805, 3);
		chk("ch4_event", {7'h00, ch4_ev}, 8'h00);
		run(3'h4, 12'h806, 2);
		run(3'h4, 12'h7F0, 1);
		run(3'h4, 12'h806, 2);
		chk("ch4_event", {7'h00, ch4_ev}, 8'h00);
		run(3'h4, 12'h806, 1);
		chk("ch4_event", {7'h00, ch4_ev}, 8'h01);
		run(3'h4, 12'h800, 1);
		chk("ch4_event", {7'h00, ch4_ev}, 8'h01);
		run(3'h4, 12'h7FD, 1);
		chk("ch4_event", {7'h00, ch4_ev}, 8'h00);
		run(3'h4, 12'h103, 3);
		chk("ch4_event", {7'h00, ch4_ev}, 8'h00);
		run(3'h4, 12'h102, 3);
		chk("ch4_event", {7'h00, ch4_ev}, 8'h01);
		run(3'h4, 12'h108, 1);
		chk("ch4_event", {7'h00, ch4_ev}, 8'h01);
		run(3'h4, 12'h10B, 1);
		chk("ch4_event", {7'h00, ch4_ev}, 8'h00);
		// channel 3: upper 0x407, lower 0x000, margin 0, n = 0
		u_wtr_host_model.wr_reg(8'h2C, 8'h70);
		u_wtr_host_model.wr_reg(8'h2D, 8'h40);
		u_wtr_host_model.wr_reg(8'h2E, 8'h00);
		u_wtr_host_model.wr_reg(8'h2F, 8'h00);
		run(3'h3, 12'h407, 1);
		chk("ch3_event", {7'h00, ch3_ev}, 8'h00);
		run(3'h3, 12'h408, 1);
		chk("ch3_event", {7'h00, ch3_ev}, 8'h01);
		chk("ch4_event", {7'h00, ch4_ev}, 8'h00);
		run(3'h5, 12'h000, 1);
		chk("ch3_event", {7'h00, ch3_ev}, 8'h01);
		run(3'h3, 12'h400, 1);
		chk("ch3_event", {7'h00, ch3_ev}, 8'h00);
		// mid-run reset with channel 3 flag raised
		run(3'h3, 12'h408, 1);
		chk("ch3_event", {7'h00, ch3_ev}, 8'h01);
		@(posedge core_clk_in);
		#1;
		sys_rst_in = 1'b1;
		repeat (2) @(posedge core_clk_in);
		#1;
		sys_rst_in = 1'b0;
		chk("ch3_event", {7'h00, ch3_ev}, 8'h00);
		rd_chk(8'h2D, 8'hFF, 1'b1);
		rd_chk(8'h30, 8'hF0, 1'b1);
		rd_chk(8'h32, 8'h00, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire

// ==== wtr_host_model.sv ====
`default_nettype none
module wtr_host_model
	import wtr_pkg::*;
(
	// clock
	input wire logic core_clk_in,
	// register port toward the bank
	output wtr_reg_wr_t reg_wr_out,
	output logic [7:0] rd_addr_out,
	input wire logic [7:0] rd_data_in,
	input wire logic rd_hit_in,
	// channel 3 margin register kept on this side
	output logic [7:0] ch3_nib_hyst_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle values at time zero
	initial begin
		reg_wr_out = '0;
		rd_addr_out = 8'h00;
		ch3_nib_hyst_out = RST_CH3_NIB_HYST;
	end

	task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge core_clk_in);
		#1;
		reg_wr_out = '{wr_en: 1'b1, addr: addr, data: data};
		if (addr == ADDR_CH3_UPPER_MSB - 8'h01) begin
			ch3_nib_hyst_out = data;
		end
		@(posedge core_clk_in);
		#1;
		// released lines no longer show the old byte
		reg_wr_out = '{wr_en: 1'b0, addr: ~addr, data: ~data};
	endtask

	task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data, output logic hit);
		@(posedge core_clk_in);
		#1;
		rd_addr_out = addr;
		@(posedge core_clk_in);
		#1;
		data = rd_data_in;
		hit = rd_hit_in;
		rd_addr_out = ~addr;
	endtask
endmodule
`default_nettype wire

// ==== wtr_pkg.sv ====
`default_nettype none
package wtr_pkg;
	// register byte addresses on the serial register port
	localparam logic [7:0] ADDR_CH3_UPPER_MSB = 8'h2D;
	localparam logic [7:0] ADDR_CH3_LOWER_NIB_CNT = 8'h2E;
	localparam logic [7:0] ADDR_CH3_LOWER_MSB = 8'h2F;
	localparam logic [7:0] ADDR_CH4_UPPER_NIB_HYST = 8'h30;
	localparam logic [7:0] ADDR_CH4_UPPER_MSB = 8'h31;
	localparam logic [7:0] ADDR_CH4_LOWER_NIB_CNT = 8'h32;
	localparam logic [7:0] ADDR_CH4_LOWER_MSB = 8'h33;
	// reset values
	localparam logic [7:0] RST_UPPER_MSB = 8'hFF;
	localparam logic [7:0] RST_UPPER_NIB_HYST = 8'hF0;
	localparam logic [7:0] RST_LOWER_NIB_CNT = 8'h00;
	localparam logic [7:0] RST_LOWER_MSB = 8'h00;
	// channel 3 margin is held outside this bank; it starts at channel 4's reset value but ignores sys_rst_in
	localparam logic [7:0] RST_CH3_NIB_HYST = 8'hF0;
	// field positions
	localparam int NIB_HI = 7;
	localparam int NIB_LO = 4;
	localparam int FLD_HI = 3;
	localparam int FLD_LO = 0;
	localparam int HYST_SHIFT = 3;
	localparam int RES_W = 12;

	// per-channel window configuration
	typedef struct packed {
		logic [RES_W-1:0] upper_limit;
		logic [RES_W-1:0] lower_limit;
		logic [3:0] margin;
		logic [3:0] sample_count;
	} wtr_win_cfg_t;

	// register write request from the serial front end
	typedef struct packed {
		logic wr_en;
		logic [7:0] addr;
		logic [7:0] data;
	} wtr_reg_wr_t;
endpackage
`default_nettype wire

// ==== wtr_window_cmp.sv ====
`default_nettype none
module wtr_window_cmp
	import wtr_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// sample and configuration
	input wire logic sample_valid_in,
	input wire logic [RES_W-1:0] sample_in,
	input wire wtr_win_cfg_t cfg_in,
	// result
	output logic event_flag_out
);
	// hysteresis as 7 bits: field with three zeros appended
	function automatic logic [RES_W-1:0] margin_of(input logic [3:0] f);
		margin_of = {5'h00, f, 3'h0};
	endfunction

	logic [3:0] run_r, run_nxt;
	logic flag_r, flag_nxt;
	logic above, below, in_win;
	logic [RES_W:0] hi_rel, lo_rel;

	// compare: top byte vs result[11:4], nibble vs result[3:0]
	always_comb begin
		above = sample_in > cfg_in.upper_limit;
		below = sample_in < cfg_in.lower_limit;
		hi_rel = {1'b0, cfg_in.upper_limit} - {1'b0, margin_of(cfg_in.margin)};
		lo_rel = {1'b0, cfg_in.lower_limit} + {1'b0, margin_of(cfg_in.margin)};
		in_win = ({1'b0, sample_in} <= hi_rel || hi_rel[RES_W])
			&& ({1'b0, sample_in} >= lo_rel);
	end

	// consecutive sample counter and flag
	always_comb begin
		run_nxt = run_r;
		flag_nxt = flag_r;
		if (sample_valid_in) begin
			if (above || below) begin
				if (run_r >= cfg_in.sample_count)
					flag_nxt = 1'b1;
				else
					run_nxt = run_r + 4'h1;
			end else if (in_win) begin
				run_nxt = 4'h0;
				flag_nxt = 1'b0;
			end else begin
				run_nxt = 4'h0;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			run_r <= 4'h0;
			flag_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
			flag_r <= flag_nxt;
		end
	end

	assign event_flag_out = flag_r;

	// checks
	a_flag_needs_run: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		$rose(flag_r) |-> $past(run_r) >= $past(cfg_in.sample_count))
		else $error("flag rose before count reached");
	a_run_clears_inside: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		sample_valid_in && !above && !below |=> run_r == 4'h0)
		else $error("run count not cleared");
	a_zero_count_fast: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		sample_valid_in && above && cfg_in.sample_count == 4'h0 |=> flag_r)
		else $error("zero count flag late");
	a_low_side_flag: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		sample_valid_in && sample_in < cfg_in.lower_limit
		&& cfg_in.sample_count == 4'h0 |=> flag_r)
		else $error("low side not flagged");
endmodule
`default_nettype wire

// ==== wtr_window_regs.sv ====
// How it works
// - upper limit top byte compared with result bits 11 to 4.
// - margin register high nibble is upper limit nibble, vs result 3:0.
// - count register high nibble is lower limit nibble, vs result 3:0.
// - lower limit top byte has own register, compared with top eight bits.
// - count field n needs n+1 consecutive out-of-window samples for flag.
// - hysteresis is field shifted left three, seven bits wide.
// - one hysteresis field serves both limits of a channel.
// - upper limit top byte resets to all ones.
// - lower byte, lower nibble and count field reset to zero.
// - channel 4 margin register resets 0xF0 at first channel address.
`default_nettype none
module wtr_window_regs
	import wtr_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// register port from the serial front end
	input wire wtr_reg_wr_t reg_wr_in,
	input wire logic [7:0] rd_addr_in,
	output logic [7:0] rd_data_out,
	output logic rd_hit_out,
	// channel 3 margin register held elsewhere
	input wire logic [7:0] ch3_nib_hyst_in,
	// conversion results
	input wire logic sample_valid_in,
	input wire logic [2:0] sample_chan_in,
	input wire logic [RES_W-1:0] sample_in,
	// event flags
	output logic ch3_event_out,
	output logic ch4_event_out
);
	localparam logic [2:0] CHAN3 = 3'h3;
	localparam logic [2:0] CHAN4 = 3'h4;

	logic [7:0] ch3_upper_limit_top_byte_r, ch3_upper_limit_top_byte_nxt;
	logic [7:0] ch3_lower_nib_cnt_r, ch3_lower_nib_cnt_nxt;
	logic [7:0] ch3_lower_limit_top_byte_r, ch3_lower_limit_top_byte_nxt;
	logic [7:0] ch4_nib_hyst_r, ch4_nib_hyst_nxt;
	logic [7:0] ch4_upper_limit_top_byte_r, ch4_upper_limit_top_byte_nxt;
	logic [7:0] ch4_lower_nib_cnt_r, ch4_lower_nib_cnt_nxt;
	logic [7:0] ch4_lower_limit_top_byte_r, ch4_lower_limit_top_byte_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;
	logic rd_hit_r, rd_hit_nxt;
	wtr_win_cfg_t ch3_cfg, ch4_cfg;

	// address match helper
	function automatic logic wr_to(input wtr_reg_wr_t w, input logic [7:0] a);
		wr_to = w.wr_en && (w.addr == a);
	endfunction

	// write decode
	always_comb begin
		ch3_upper_limit_top_byte_nxt = ch3_upper_limit_top_byte_r;
		ch3_lower_nib_cnt_nxt = ch3_lower_nib_cnt_r;
		ch3_lower_limit_top_byte_nxt = ch3_lower_limit_top_byte_r;
		ch4_nib_hyst_nxt = ch4_nib_hyst_r;
		ch4_upper_limit_top_byte_nxt = ch4_upper_limit_top_byte_r;
		ch4_lower_nib_cnt_nxt = ch4_lower_nib_cnt_r;
		ch4_lower_limit_top_byte_nxt = ch4_lower_limit_top_byte_r;
		if (wr_to(reg_wr_in, ADDR_CH3_UPPER_MSB))
			ch3_upper_limit_top_byte_nxt = reg_wr_in.data;
		if (wr_to(reg_wr_in, ADDR_CH3_LOWER_NIB_CNT))
			ch3_lower_nib_cnt_nxt = reg_wr_in.data;
		if (wr_to(reg_wr_in, ADDR_CH3_LOWER_MSB))
			ch3_lower_limit_top_byte_nxt = reg_wr_in.data;
		if (wr_to(reg_wr_in, ADDR_CH4_UPPER_NIB_HYST))
			ch4_nib_hyst_nxt = reg_wr_in.data;
		if (wr_to(reg_wr_in, ADDR_CH4_UPPER_MSB))
			ch4_upper_limit_top_byte_nxt = reg_wr_in.data;
		if (wr_to(reg_wr_in, ADDR_CH4_LOWER_NIB_CNT))
			ch4_lower_nib_cnt_nxt = reg_wr_in.data;
		if (wr_to(reg_wr_in, ADDR_CH4_LOWER_MSB))
			ch4_lower_limit_top_byte_nxt = reg_wr_in.data;
	end

	// register storage
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			ch3_upper_limit_top_byte_r <= RST_UPPER_MSB;
			ch4_upper_limit_top_byte_r <= RST_UPPER_MSB;
			ch3_lower_nib_cnt_r <= RST_LOWER_NIB_CNT;
			ch3_lower_limit_top_byte_r <= RST_LOWER_MSB;
			ch4_lower_nib_cnt_r <= RST_LOWER_NIB_CNT;
			ch4_lower_limit_top_byte_r <= RST_LOWER_MSB;
			ch4_nib_hyst_r <= RST_UPPER_NIB_HYST;
		end else begin
			ch3_upper_limit_top_byte_r <= ch3_upper_limit_top_byte_nxt;
			ch3_lower_nib_cnt_r <= ch3_lower_nib_cnt_nxt;
			ch3_lower_limit_top_byte_r <= ch3_lower_limit_top_byte_nxt;
			ch4_nib_hyst_r <= ch4_nib_hyst_nxt;
			ch4_upper_limit_top_byte_r <= ch4_upper_limit_top_byte_nxt;
			ch4_lower_nib_cnt_r <= ch4_lower_nib_cnt_nxt;
			ch4_lower_limit_top_byte_r <= ch4_lower_limit_top_byte_nxt;
		end
	end

	// read mux, one cycle latency
	always_comb begin
		rd_hit_nxt = 1'b1;
		case (rd_addr_in)
			ADDR_CH3_UPPER_MSB: rd_data_nxt = ch3_upper_limit_top_byte_r;
			ADDR_CH3_LOWER_NIB_CNT: rd_data_nxt = ch3_lower_nib_cnt_r;
			ADDR_CH3_LOWER_MSB: rd_data_nxt = ch3_lower_limit_top_byte_r;
			ADDR_CH4_UPPER_NIB_HYST: rd_data_nxt = ch4_nib_hyst_r;
			ADDR_CH4_UPPER_MSB: rd_data_nxt = ch4_upper_limit_top_byte_r;
			ADDR_CH4_LOWER_NIB_CNT: rd_data_nxt = ch4_lower_nib_cnt_r;
			ADDR_CH4_LOWER_MSB: rd_data_nxt = ch4_lower_limit_top_byte_r;
			default: begin
				rd_data_nxt = 8'h00;
				rd_hit_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			rd_data_r <= 8'h00;
			rd_hit_r <= 1'b0;
		end else begin
			rd_data_r <= rd_data_nxt;
			rd_hit_r <= rd_hit_nxt;
		end
	end

	assign rd_data_out = rd_data_r;
	assign rd_hit_out = rd_hit_r;

	// assemble 12-bit limits from byte plus nibble
	always_comb begin
		ch3_cfg.upper_limit = {ch3_upper_limit_top_byte_r, ch3_nib_hyst_in[NIB_HI:NIB_LO]};
		ch3_cfg.lower_limit = {ch3_lower_limit_top_byte_r, ch3_lower_nib_cnt_r[NIB_HI:NIB_LO]};
		ch3_cfg.margin = ch3_nib_hyst_in[FLD_HI:FLD_LO];
		ch3_cfg.sample_count = ch3_lower_nib_cnt_r[FLD_HI:FLD_LO];
		ch4_cfg.upper_limit = {ch4_upper_limit_top_byte_r, ch4_nib_hyst_r[NIB_HI:NIB_LO]};
		ch4_cfg.lower_limit = {ch4_lower_limit_top_byte_r, ch4_lower_nib_cnt_r[NIB_HI:NIB_LO]};
		ch4_cfg.margin = ch4_nib_hyst_r[FLD_HI:FLD_LO];
		ch4_cfg.sample_count = ch4_lower_nib_cnt_r[FLD_HI:FLD_LO];
	end

	wtr_window_cmp u_cmp_ch3 (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.sample_valid_in(sample_valid_in && sample_chan_in == CHAN3),
		.sample_in(sample_in),
		.cfg_in(ch3_cfg),
		.event_flag_out(ch3_event_out)
	);

	wtr_window_cmp u_cmp_ch4 (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.sample_valid_in(sample_valid_in && sample_chan_in == CHAN4),
		.sample_in(sample_in),
		.cfg_in(ch4_cfg),
		.event_flag_out(ch4_event_out)
	);

	// checks
	a_write_readback: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		wr_to(reg_wr_in, ADDR_CH4_UPPER_MSB) |=> ch4_upper_limit_top_byte_r == $past(reg_wr_in.data))
		else $error("write not stored");
	a_read_latency: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		rd_addr_in == ADDR_CH4_UPPER_NIB_HYST && !reg_wr_in.wr_en
		|=> rd_data_out == ch4_nib_hyst_r && rd_hit_out)
		else $error("read data wrong");
	a_reset_values: assert property (@(posedge core_clk_in)
		!sys_rst_in && $past(sys_rst_in)
		|-> ch4_nib_hyst_r == 8'hF0 && ch3_upper_limit_top_byte_r == 8'hFF
		&& ch4_lower_nib_cnt_r == 8'h00)
		else $error("reset value wrong");
	a_unmapped_zero: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		rd_addr_in == 8'h34 |=> rd_data_out == 8'h00 && !rd_hit_out)
		else $error("unmapped read not zero");
	a_limit_assembly: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		ch4_cfg.upper_limit[3:0] == ch4_nib_hyst_r[7:4]
		&& ch4_cfg.lower_limit[11:4] == ch4_lower_limit_top_byte_r)
		else $error("limit assembly wrong");
	a_upper_default_max: assert property (@(posedge core_clk_in)
		!sys_rst_in && $past(sys_rst_in) |-> ch4_cfg.upper_limit == 12'hFFF)
		else $error("upper limit not max");
endmodule
`default_nettype wire
